/* File: mdsp_defs.svh */
// Register offsets, field positions, reset values and timing counts of the serial slave port
`ifndef MDSP_DEFS_SVH
`define MDSP_DEFS_SVH
`define MDSP_CLK_HZ        20000000
`define MDSP_CLK_NS        50
`define MDSP_MS_NS         1000000
`define MDSP_MS_CYCLES     (`MDSP_MS_NS / `MDSP_CLK_NS)
`define MDSP_OVERSAMPLE    16
`define MDSP_OFF_CTRL      8'h00
`define MDSP_OFF_ADDR      8'h04
`define MDSP_OFF_GAP       8'h08
`define MDSP_OFF_TURN      8'h0C
`define MDSP_OFF_CMD       8'h10
`define MDSP_OFF_STATUS    8'h14
`define MDSP_OFF_RXDATA    8'h18
`define MDSP_OFF_TXDATA    8'h1C
`define MDSP_OFF_TXWORD    8'h20
`define MDSP_OFF_INT_STAT  8'h24
`define MDSP_OFF_INT_CLR   8'h28
`define MDSP_OFF_INT_EN    8'h2C
`define MDSP_OFF_ALARM     8'h30
`define MDSP_CTRL_RST      12'h038
`define MDSP_UNIT_RST      10'h07B
`define MDSP_BCAST_RST     10'h3E6
`define MDSP_GAP_RST       14'h03E8
`define MDSP_TURN_RST      10'h064
`define MDSP_FN_READ       8'h03
`define MDSP_FN_TASK       8'h06
`define MDSP_FN_WRITE      8'h10
`define MDSP_ASCII_ZERO    8'h30
`define MDSP_INT_RXBYTE    0
`define MDSP_INT_GAP       1
`define MDSP_INT_RXERR     2
`define MDSP_INT_TXRDY     3
`define MDSP_INT_TASK      4
`define MDSP_INT_BADFN     5
`define MDSP_INT_OVR       6
`define MDSP_INT_W         7
`endif

/* File: mdsp_host_model.sv */
// Remote polling master: drives requests and collects reply characters
`timescale 1ns/1ns
module mdsp_host_model #(
  parameter int BIT = 160
) (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic tx_en,
  output logic      rxd,
  output logic      rx_stb,
  output logic [7:0] rx_byte
);
  // Only one unit sits on this line, well inside the loop limit
  initial begin
    rxd = 1'b1;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // Even parity, one stop, LSB first; the bias network keeps the idle line high
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Bits sampled mid-way; one format both ways in this test
  always @(posedge clk) begin
    if (tx_en && !txd) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        rx_byte[i] <= txd;
      end
      repeat (2 * BIT) @(posedge clk);
      rx_stb <= 1'b1;
      @(posedge clk);
      rx_stb <= 1'b0;
    end
  end
endmodule

/* File: mdsp_pkg.sv */
// Types shared by the serial slave port modules
package mdsp_pkg;
  typedef enum logic [2:0] {
    MDSP_IDLE, MDSP_ADDR, MDSP_RECV, MDSP_SKIP, MDSP_TURN, MDSP_REPLY
  } mdsp_state_t;
  typedef enum logic [2:0] {
    MDSP_P_VENDOR_A, MDSP_P_VENDOR_B, MDSP_P_VENDOR_C, MDSP_P_MBRTU, MDSP_P_MBLEG
  } mdsp_proto_t;
  typedef enum logic [1:0] {MDSP_PAR_NONE, MDSP_PAR_EVEN, MDSP_PAR_ODD} mdsp_parity_t;
endpackage

/* File: mdsp_top.sv */
// Multidrop serial slave port: APB registers, address match, gap and turnaround timing
//
// Operation
// - Slave only; transmit solely answering a poll.
// - Line rate selectable, 1200 to 128000 baud.
// - Eight data bits, parity none/even/odd, 1-2 stops.
// - Gap between characters over limit times out.
// - Wait turnaround delay before answering.
// - Broadcast address executes, never replies.
// - Three-digit primary address identifies the unit.
// - Modbus multi-byte values follow byte-order setting.
// - Modbus function 06h means execute a task.
// - Modbus accepts only three function codes.
// - Setting selects one of five protocols.
// - Report alarms, clear them on command.
// - Configuration writes act immediately.
// - First vendor protocol: two message formats.
// - Second vendor protocol: one format both ways.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "mdsp_defs.svh"
module mdsp_top
  import mdsp_pkg::*;
#(
  parameter int MS_CYCLES = `MDSP_MS_CYCLES,
  parameter int ALARM_W   = 8
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RESETN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic [31:0]             PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               RXD,
  output logic                    TXD,
  output logic                    TX_EN,
  input  wire logic [ALARM_W-1:0] ALARM_ACTIVE,
  output logic                    ALARM_CLEAR,
  output logic                    IRQ
);

  logic [11:0]           ctrl_reg;
  logic [9:0]            unit_reg, bcast_reg;
  logic [13:0]           gap_reg;
  logic [9:0]            turn_reg;
  logic [`MDSP_INT_W-1:0] int_stat_reg, int_en_reg, int_set;
  mdsp_state_t           state_reg;
  logic [9:0]            acc_reg;
  logic [1:0]            dig_reg;
  logic                  bcast_hit_reg;
  logic [7:0]            fn_reg;
  logic                  fn_seen_reg;
  logic [13:0]           gap_cnt_reg;
  logic [9:0]            turn_cnt_reg;
  logic [31:0]           ms_cnt_reg;
  logic                  ms_tick;
  logic [7:0]            rxd_reg;
  logic                  rx_full_reg;
  logic [15:0]           tx_buf_reg;
  logic [1:0]            tx_cnt_reg;
  logic                  end_pend_reg;
  logic                  wr, rd_setup, wr_cmd;
  logic                  mapped;
  logic                  enable, stop2, byte_swap;
  mdsp_proto_t           proto;
  logic                  modbus;
  logic [3:0]            baud_sel;
  logic [1:0]            parity;
  logic                  rx_valid, rx_err, tx_ready, tx_busy, tx_go;
  logic [7:0]            rx_data, digit;
  logic [9:0]            addr_val;
  logic                  unit_hit, bcast_hit, gap_out;

  // Control fields are decoded straight from the register so writes act at once
  assign enable    = ctrl_reg[0];
  assign proto     = mdsp_proto_t'(ctrl_reg[3:1]);
  assign baud_sel  = ctrl_reg[7:4];
  assign parity    = ctrl_reg[9:8];
  assign stop2     = ctrl_reg[10];
  assign byte_swap = ctrl_reg[11];
  assign modbus    = (proto == MDSP_P_MBRTU) || (proto == MDSP_P_MBLEG);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle
  assign wr       = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PREADY   = PSEL && PENABLE;
  assign wr_cmd   = wr && PADDR == `MDSP_OFF_CMD;

  always_comb begin
    unique case (PADDR)
      `MDSP_OFF_CTRL, `MDSP_OFF_ADDR, `MDSP_OFF_GAP, `MDSP_OFF_TURN,
      `MDSP_OFF_CMD, `MDSP_OFF_STATUS, `MDSP_OFF_RXDATA, `MDSP_OFF_TXDATA,
      `MDSP_OFF_TXWORD, `MDSP_OFF_INT_STAT, `MDSP_OFF_INT_CLR,
      `MDSP_OFF_INT_EN, `MDSP_OFF_ALARM: mapped = 1'b1;
      default:                            mapped = 1'b0;
    endcase
  end
  // Unmapped offsets answer with an error and read as zero
  assign PSLVERR = PREADY && !mapped;

  // Configuration registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg   <= `MDSP_CTRL_RST;
      unit_reg   <= `MDSP_UNIT_RST;
      bcast_reg  <= `MDSP_BCAST_RST;
      gap_reg    <= `MDSP_GAP_RST;
      turn_reg   <= `MDSP_TURN_RST;
      int_en_reg <= '0;
    end else if (wr) begin
      unique case (PADDR)
        `MDSP_OFF_CTRL: ctrl_reg <= PWDATA[11:0];
        `MDSP_OFF_ADDR: begin
          unit_reg  <= PWDATA[9:0];
          bcast_reg <= PWDATA[25:16];
        end
        `MDSP_OFF_GAP:    gap_reg    <= PWDATA[13:0];
        `MDSP_OFF_TURN:   turn_reg   <= PWDATA[9:0];
        `MDSP_OFF_INT_EN: int_en_reg <= PWDATA[`MDSP_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered so PRDATA is stable through the access phase
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (rd_setup) begin
      unique case (PADDR)
        `MDSP_OFF_CTRL:     PRDATA <= {20'h00000, ctrl_reg};
        `MDSP_OFF_ADDR:     PRDATA <= {6'h00, bcast_reg, 6'h00, unit_reg};
        `MDSP_OFF_GAP:      PRDATA <= {18'h00000, gap_reg};
        `MDSP_OFF_TURN:     PRDATA <= {22'h000000, turn_reg};
        `MDSP_OFF_STATUS:   PRDATA <= {16'h0000, fn_reg, 1'b0, tx_busy,
                                       state_reg == MDSP_REPLY && tx_cnt_reg == 2'h0,
                                       bcast_hit_reg, rx_full_reg, state_reg};
        `MDSP_OFF_RXDATA:   PRDATA <= {23'h000000, rx_full_reg, rxd_reg};
        `MDSP_OFF_INT_STAT: PRDATA <= 32'(int_stat_reg);
        `MDSP_OFF_INT_EN:   PRDATA <= 32'(int_en_reg);
        `MDSP_OFF_ALARM:    PRDATA <= 32'(ALARM_ACTIVE);
        default:            PRDATA <= 32'h00000000;
      endcase
    end
  end

  // Alarm clear is a one-cycle pulse to the application
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ALARM_CLEAR <= 1'b0;
    end else begin
      ALARM_CLEAR <= wr_cmd && PWDATA[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character framer
  mdsp_uart #(
    .CLK_HZ (`MDSP_CLK_HZ)
  ) u_uart (
    .clk      (SYS_CLK),
    .rstn     (RESETN),
    .rxd_pin  (RXD),
    .baud_sel (baud_sel),
    .parity   (parity),
    .stop2    (stop2),
    .tx_valid (tx_go),
    .tx_data  (tx_buf_reg[7:0]),
    .tx_ready (tx_ready),
    .tx_busy  (tx_busy),
    .txd      (TXD),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_err   (rx_err)
  );
  // Driver enabled only while a reply character is on the line
  assign TX_EN = tx_busy;

  // Millisecond enable shared by gap and turnaround timers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ms_cnt_reg <= 32'h00000000;
    end else if (ms_cnt_reg >= 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h00000000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end
  end
  assign ms_tick = (ms_cnt_reg == 32'h00000000);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding: one binary byte for Modbus, three ASCII digits otherwise
  assign digit     = rx_data - `MDSP_ASCII_ZERO;
  assign addr_val  = modbus ? {2'b00, rx_data} : 10'(acc_reg * 10 + {6'h00, digit[3:0]});
  assign unit_hit  = (addr_val == unit_reg);
  assign bcast_hit = (addr_val == bcast_reg);

  // Gap timer restarts on every character; free-running ms phase costs up to 1 ms
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gap_cnt_reg <= 14'h0000;
    end else if (rx_valid || state_reg == MDSP_IDLE) begin
      gap_cnt_reg <= 14'h0000;
    end else if (ms_tick && gap_cnt_reg != 14'h3FFF) begin
      gap_cnt_reg <= gap_cnt_reg + 14'h0001;
    end
  end
  assign gap_out = ms_tick && !rx_valid && gap_cnt_reg >= gap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Record sequencer; framing of vendor payloads is left to software
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg     <= MDSP_IDLE;
      acc_reg       <= 10'h000;
      dig_reg       <= 2'h0;
      bcast_hit_reg <= 1'b0;
      turn_cnt_reg  <= 10'h000;
    end else if (!enable) begin
      state_reg <= MDSP_IDLE;
    end else begin
      unique case (state_reg)
        MDSP_IDLE: begin
          acc_reg <= 10'h000;
          dig_reg <= 2'h0;
          if (rx_valid && modbus) begin
            bcast_hit_reg <= bcast_hit;
            state_reg <= (unit_hit || bcast_hit) ? MDSP_RECV : MDSP_SKIP;
          end else if (rx_valid) begin
            acc_reg   <= addr_val;
            dig_reg   <= 2'h1;
            state_reg <= MDSP_ADDR;
          end
        end
        MDSP_ADDR: begin
          if (gap_out) begin
            state_reg <= MDSP_IDLE;
          end else if (rx_valid && dig_reg == 2'h2) begin
            bcast_hit_reg <= bcast_hit;
            state_reg <= (unit_hit || bcast_hit) ? MDSP_RECV : MDSP_SKIP;
          end else if (rx_valid) begin
            acc_reg <= addr_val;
            dig_reg <= dig_reg + 2'h1;
          end
        end
        MDSP_SKIP: begin
          if (gap_out) begin
            state_reg <= MDSP_IDLE;
          end
        end
        MDSP_RECV: begin
          if (gap_out) begin
            state_reg <= MDSP_IDLE;
          end else if (wr_cmd && PWDATA[0]) begin
            turn_cnt_reg <= 10'h000;
            // Broadcast requests are acted on by software but never answered
            state_reg <= bcast_hit_reg ? MDSP_IDLE : MDSP_TURN;
          end
        end
        MDSP_TURN: begin
          if (turn_cnt_reg >= turn_reg) begin
            state_reg <= MDSP_REPLY;
          end else if (ms_tick) begin
            turn_cnt_reg <= turn_cnt_reg + 10'h001;
          end
        end
        MDSP_REPLY: begin
          if (end_pend_reg && tx_cnt_reg == 2'h0 && !tx_busy) begin
            state_reg <= MDSP_IDLE;
          end
        end
        default: state_reg <= MDSP_IDLE;
      endcase
    end
  end

  // Modbus function code is the first payload byte of an accepted record
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fn_reg      <= 8'h00;
      fn_seen_reg <= 1'b0;
    end else if (state_reg != MDSP_RECV) begin
      fn_seen_reg <= 1'b0;
    end else if (rx_valid && !fn_seen_reg) begin
      fn_reg      <= rx_data;
      fn_seen_reg <= 1'b1;
    end
  end

  // Receive holding register; a read of RXDATA pops it
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rxd_reg     <= 8'h00;
      rx_full_reg <= 1'b0;
    end else if (rx_valid && state_reg == MDSP_RECV) begin
      rxd_reg     <= rx_data;
      rx_full_reg <= 1'b1; // New byte wins over a pop in the same cycle
    end else if (rd_setup && PADDR == `MDSP_OFF_RXDATA) begin
      rx_full_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply buffer: a byte or a 16-bit value, only accepted in the reply phase
  assign tx_go = state_reg == MDSP_REPLY && tx_cnt_reg != 2'h0;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_buf_reg   <= 16'h0000;
      tx_cnt_reg   <= 2'h0;
      end_pend_reg <= 1'b0;
    end else if (state_reg != MDSP_REPLY) begin
      tx_cnt_reg   <= 2'h0;
      end_pend_reg <= 1'b0;
    end else begin
      if (wr_cmd && PWDATA[1]) begin
        end_pend_reg <= 1'b1;
      end
      if (tx_go && tx_ready) begin
        tx_buf_reg <= {8'h00, tx_buf_reg[15:8]};
        tx_cnt_reg <= tx_cnt_reg - 2'h1;
      end else if (wr && tx_cnt_reg == 2'h0 && PADDR == `MDSP_OFF_TXDATA) begin
        tx_buf_reg <= {8'h00, PWDATA[7:0]};
        tx_cnt_reg <= 2'h1;
      end else if (wr && tx_cnt_reg == 2'h0 && PADDR == `MDSP_OFF_TXWORD) begin
        // Default sends the high byte first; swap sends the low byte first
        tx_buf_reg <= byte_swap ? PWDATA[15:0] : {PWDATA[7:0], PWDATA[15:8]};
        tx_cnt_reg <= 2'h2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  always_comb begin
    int_set = '0;
    int_set[`MDSP_INT_RXBYTE] = rx_valid && state_reg == MDSP_RECV;
    int_set[`MDSP_INT_GAP]    = gap_out && (state_reg == MDSP_RECV || state_reg == MDSP_ADDR);
    int_set[`MDSP_INT_RXERR]  = rx_valid && rx_err && enable;
    int_set[`MDSP_INT_TXRDY]  = state_reg == MDSP_TURN && turn_cnt_reg >= turn_reg && enable;
    int_set[`MDSP_INT_TASK]   = modbus && rx_valid && state_reg == MDSP_RECV && !fn_seen_reg
                                && rx_data == `MDSP_FN_TASK;
    int_set[`MDSP_INT_BADFN]  = modbus && rx_valid && state_reg == MDSP_RECV && !fn_seen_reg
                                && rx_data != `MDSP_FN_READ && rx_data != `MDSP_FN_TASK
                                && rx_data != `MDSP_FN_WRITE;
    int_set[`MDSP_INT_OVR]    = rx_valid && state_reg == MDSP_RECV && rx_full_reg;
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~((wr && PADDR == `MDSP_OFF_INT_CLR)
                       ? PWDATA[`MDSP_INT_W-1:0] : '0)) | int_set;
    end
  end
  assign IRQ = |(int_stat_reg & int_en_reg);
endmodule

/* File: mdsp_top_monitor.sv */
// Concurrent checks on the serial slave port pins
`timescale 1ns/1ns
module mdsp_top_monitor #(
  parameter int ALARM_W = 8
) (
  input wire logic               SYS_CLK,
  input wire logic               RESETN,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               TXD,
  input wire logic               TX_EN,
  input wire logic [ALARM_W-1:0] ALARM_ACTIVE,
  input wire logic               ALARM_CLEAR
);
  logic clr_wr;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Command write asking for an alarm clear
  assign clr_wr = PSEL && PENABLE && PWRITE && PADDR == 8'h10 && PWDATA[2];
  ////////////////////////////////////////////////////////////////////////////////
  // Zero wait states, so a write lands at once
  property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_err; PSEL && PENABLE && PADDR > 8'h30 |-> PSLVERR; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  // A line left undriven must sit at mark, never a stray space
  property p_idle; !TX_EN |-> TXD; endproperty
  a_idle: assert property (p_idle) else $error("txd low while idle");
  property p_start; $rose(TX_EN) |-> ##[0:2] !TXD; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_frame; $rose(TX_EN) |=> TX_EN [*8]; endproperty
  a_frame: assert property (p_frame) else $error("driver dropped early");
  // Clear is a single registered pulse tied to its command
  property p_clr1; ALARM_CLEAR |=> !ALARM_CLEAR; endproperty
  a_clr1: assert property (p_clr1) else $error("clear too long");
  property p_clrc; $rose(ALARM_CLEAR) |-> $past(clr_wr); endproperty
  a_clrc: assert property (p_clrc) else $error("clear without command");
  property p_alrm; PSEL && PENABLE && !PWRITE && PADDR == 8'h30
    |-> PRDATA[ALARM_W-1:0] == $past(ALARM_ACTIVE); endproperty
  a_alrm: assert property (p_alrm) else $error("alarm readback wrong");
endmodule

/* File: mdsp_uart.sv */
// Character framer: pin synchroniser, baud divider, receiver and transmitter
`timescale 1ns/1ns
`include "mdsp_defs.svh"
module mdsp_uart
  import mdsp_pkg::*;
#(
  parameter int CLK_HZ = `MDSP_CLK_HZ
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       rxd_pin,
  input  wire logic [3:0] baud_sel,
  input  wire logic [1:0] parity,
  input  wire logic       stop2,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            tx_busy,
  output logic            txd,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err
);
  logic [15:0] div;
  logic [15:0] div_cnt_reg;
  logic        tick;
  logic        s1_reg, s2_reg, s3_reg, rx_f_reg;
  logic        par_en, par_odd;
  logic [3:0]  rx_sub_reg, tx_sub_reg;
  logic [3:0]  rx_bit_reg, tx_bit_reg;
  logic        rx_busy_reg;
  logic [9:0]  rx_sh_reg;
  logic [11:0] tx_sh_reg;

  assign par_en  = (parity != MDSP_PAR_NONE);
  assign par_odd = (parity == MDSP_PAR_ODD);

  // Oversample divisor per selectable line rate; rounding is to nearest cycle
  always_comb begin
    unique case (baud_sel)
      4'h0:    div = 16'((CLK_HZ + 8 * 1200) / (16 * 1200));
      4'h1:    div = 16'((CLK_HZ + 8 * 2400) / (16 * 2400));
      4'h2:    div = 16'((CLK_HZ + 8 * 4800) / (16 * 4800));
      4'h3:    div = 16'((CLK_HZ + 8 * 9600) / (16 * 9600));
      4'h4:    div = 16'((CLK_HZ + 8 * 19200) / (16 * 19200));
      4'h5:    div = 16'((CLK_HZ + 8 * 38400) / (16 * 38400));
      4'h6:    div = 16'((CLK_HZ + 8 * 57600) / (16 * 57600));
      4'h7:    div = 16'((CLK_HZ + 8 * 115200) / (16 * 115200));
      default: div = 16'((CLK_HZ + 8 * 128000) / (16 * 128000));
    endcase
  end

  // Oversample enable pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 16'h0000;
    end else if (div_cnt_reg >= div - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end
  assign tick = (div_cnt_reg == 16'h0000);

  // Three-stage pin synchroniser; level moves only when stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      s3_reg   <= 1'b1;
      rx_f_reg <= 1'b1;
    end else begin
      s1_reg <= rxd_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        rx_f_reg <= s3_reg;
      end
    end
  end

  // Receiver: start is confirmed at mid bit, then each bit is sampled mid cell
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_busy_reg <= 1'b0;
      rx_sub_reg  <= 4'h0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 10'h000;
      rx_valid    <= 1'b0;
      rx_err      <= 1'b0;
      rx_data     <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (tick) begin
        if (!rx_busy_reg) begin
          rx_sub_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
          rx_busy_reg <= !rx_f_reg;
        end else begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_bit_reg == 4'h0 && rx_sub_reg == 4'h7) begin
            rx_sub_reg <= 4'h0;
            rx_bit_reg <= 4'h1;
            rx_busy_reg <= !rx_f_reg; // Glitch shorter than half a bit is dropped
          end else if (rx_bit_reg != 4'h0 && rx_sub_reg == 4'hF) begin
            rx_sh_reg  <= {rx_f_reg, rx_sh_reg[9:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == (par_en ? 4'hA : 4'h9)) begin
              rx_busy_reg <= 1'b0;
              rx_valid    <= 1'b1;
              if (par_en) begin
                rx_data <= rx_sh_reg[8:1];
                rx_err  <= !rx_f_reg || (^rx_sh_reg[9:1] != par_odd);
              end else begin
                rx_data <= rx_sh_reg[9:2];
                rx_err  <= !rx_f_reg;
              end
            end
          end
        end
      end
    end
  end

  // Transmitter: whole frame is loaded into a shift register, LSB first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_reg  <= 12'hFFF;
      tx_bit_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else if (tx_valid && tx_ready) begin
      tx_sh_reg  <= par_en ? {2'b11, (^tx_data) ^ par_odd, tx_data, 1'b0}
                           : {3'b111, tx_data, 1'b0};
      tx_bit_reg <= 4'hA + {3'b000, par_en} + {3'b000, stop2};
      tx_sub_reg <= 4'h0;
    end else if (tick && tx_bit_reg != 4'h0) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_sub_reg == 4'hF) begin
        tx_sh_reg  <= {1'b1, tx_sh_reg[11:1]};
        tx_bit_reg <= tx_bit_reg - 4'h1;
      end
    end
  end
  assign tx_ready = (tx_bit_reg == 4'h0);
  assign tx_busy  = !tx_ready;
  assign txd      = tx_sh_reg[0];
endmodule

/* File: multidrop_serial_slave_port_tb.sv */
// Self-checking bench for the serial slave port
`timescale 1ns/1ns
module multidrop_serial_slave_port_tb;
  logic        SYS_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD, TXD, TX_EN;
  logic        ALARM_CLEAR, IRQ, rx_stb, slv;
  logic [7:0]  PADDR, ALARM_ACTIVE, rx_byte;
  logic [31:0] PWDATA, PRDATA, rdv;
  logic [7:0]  exp_q[$];
  logic [31:0] rst_tab[4] = '{32'h38, 32'h03E6007B, 32'h3E8, 32'h64};
  logic [39:0] cfg[4] = '{{8'h08, 32'h3}, {8'h0C, 32'h1}, {8'h2C, 32'h7F}, {8'h00, 32'h187}};
  int          fails, samples_checked, tx_rises, n, clr_n;
  mdsp_top #(.MS_CYCLES(1000)) mdsp_top_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .TX_EN(TX_EN),
    .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_CLEAR(ALARM_CLEAR), .IRQ(IRQ));
  mdsp_host_model mdsp_host_model_i (.clk(SYS_CLK), .txd(TXD), .tx_en(TX_EN), .rxd(RXD),
    .rx_stb(rx_stb), .rx_byte(rx_byte));
  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge TX_EN) tx_rises++;
  always @(posedge ALARM_CLEAR) clr_n++;
  // Each reply character retires the oldest expected byte
  always @(posedge rx_stb) chk("reply", exp_q.size() ? exp_q.pop_front() : 32'hX, rx_byte);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; waits out pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    {rdv, slv} = {PRDATA, PSLVERR};
    fails += (n == 20);
    if (n == 20) tally_and_finish();
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic req(input logic [7:0] a);
    mdsp_host_model_i.send(a);
    mdsp_host_model_i.send(8'h06);
  endtask
  task automatic tally_and_finish;
    chk("left", 0, exp_q.size());
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge SYS_CLK);
    fails++;
    tally_and_finish();
  end
  initial begin
    {SYS_CLK, RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, ALARM_ACTIVE} = 0;
    {fails, samples_checked, tx_rises} = 0;
    void'($urandom(32'hDF2C));
    repeat (2) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("reset word", rst_tab[i], rdv);
    end
    foreach (cfg[i]) apb(1, cfg[i][39:32], cfg[i][31:0]);
    // Polled request: task code, then reply after the turnaround
    req(8'h7B);
    apb(0, 8'h14, 0);
    chk("fn", 32'h600, rdv & 32'hFF00);
    apb(0, 8'h18, 0);
    chk("rx", 32'h106, rdv & 32'h1FF);
    chk("irq", 1, IRQ);
    apb(1, 8'h10, 1);
    for (int i = 0; i < 900 && rdv[2:0] !== 3'h5; i++) apb(0, 8'h14, 0);
    chk("turn", 5, {tx_rises[28:0], rdv[2:0]});
    exp_q.push_back(8'($urandom));
    apb(1, 8'h1C, {24'h0, exp_q[0]});
    apb(1, 8'h10, 2);
    repeat (2200) @(posedge SYS_CLK);
    $display("test reply done");
    // Broadcast acts but stays silent; foreign record ignored
    apb(1, 8'h04, 32'h0020007B);
    req(8'h20);
    apb(0, 8'h14, 0);
    chk("bcast", 32'h10, rdv & 32'h10);
    apb(1, 8'h10, 1);
    req(8'h55);
    repeat (4000) @(posedge SYS_CLK);
    apb(0, 8'h18, 0);
    chk("silent", 32'h20D, {rdv[30:0], tx_rises[0]});
    $display("test addressing done");
    // Text address of three digits, then silence runs into the gap limit
    apb(1, 8'h28, 32'h7F);
    apb(1, 8'h00, 32'h181);
    for (int i = 49; i < 52; i++) mdsp_host_model_i.send(8'(i));
    repeat (4000) @(posedge SYS_CLK);
    apb(0, 8'h24, 0);
    chk("gap", 2, rdv & 2);
    apb(0, 8'h14, 0);
    chk("idle", 0, rdv & 7);
    ALARM_ACTIVE <= 8'($urandom);
    apb(0, 8'h30, 0);
    chk("alarm", {24'h0, ALARM_ACTIVE}, rdv);
    apb(1, 8'h10, 4);
    apb(1, 8'h28, 32'h7F);
    apb(0, 8'h40, 0);
    chk("unmapped", 5, {rdv[28:0], clr_n[0], IRQ, slv});
    $display("test alarm done");
    tally_and_finish();
  end
endmodule
bind mdsp_top mdsp_top_monitor #(.ALARM_W(ALARM_W)) mon_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TXD(TXD), .TX_EN(TX_EN),
  .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_CLEAR(ALARM_CLEAR));
